// ===== include/fds_regs.vh
// Register offsets, field positions and reset values of the divider config.
`ifndef FDS_REGS_VH
`define FDS_REGS_VH
// Word indexes; byte address is four times the index.
`define FDS_IDX_MOD_CTRL      6'h0e
`define FDS_IDX_DIV_CFG       6'h0f
`define FDS_IDX_DWELL_HI      6'h10
`define FDS_IDX_DWELL_LO      6'h11
// Modulator and sweep control fields.
`define FDS_SLIP_STEP_LSB     15
`define FDS_SLIP_STEP_MSB     18
`define FDS_SYM_BIT           22
`define FDS_EXT_CLK_BIT       27
`define FDS_X16_BIT           29
`define FDS_MOD_CTRL_MASK     32'h284f_f800
`define FDS_MOD_CTRL_RST      32'h0047_8000
// Divider configuration fields.
`define FDS_WIDE_MOD_BIT      0
`define FDS_WIDE_CMP_BIT      1
`define FDS_BUFCUR_LSB        2
`define FDS_BUFCUR_MSB        4
`define FDS_DIVRST_BIT        5
`define FDS_RESYNC_LSB        6
`define FDS_RESYNC_MSB        8
`define FDS_RFBIAS_LSB        9
`define FDS_RFBIAS_MSB        11
`define FDS_PW_LSB            12
`define FDS_PW_MSB            14
`define FDS_DIV_CFG_RST       15'h32ce
// Timing of the divided pulse.
`define FDS_PW_BASE           6'h05
`define FDS_PW_STEP_SHIFT     3
`define FDS_WIDE_MIN_RATIO    20'h0_0040
`endif

// ===== hdl/fds_divider_cfg.v
// Divider configuration, slip guard, clock select and dwell registers.
//
// Functional notes
// - External clock bit set: modulator runs from GPIO clock, else divided.
// - x16 bit set: slip-guard step times sixteen, else unchanged.
// - Modulator pulse widening applies only while division ratio exceeds 64.
// - Detector widening bit, default set, stretches comparator clock low.
// - Divider reset bit holds the RF divider in reset while set.
// - Output pulse width is 5 plus 8 times code cycles, reset 011.
// - Upper 30 dwell bits from dwell-high register, reset zero.
// - Lower 18 dwell bits from dwell-low register, reset zero.
// - Symmetric bit set shares up and down; clear uses down registers only while sweeping down.
// - Base slip-guard step is 4 bits, reset all ones.
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "fds_regs.vh"
module fds_divider_cfg #(
   parameter DIV_W = 20
) (
   // Clock and reset.
   input  wire             core_clk,
   input  wire             rst,
   // Avalon-MM slave.
   input  wire [7:0]       avs_address,
   input  wire             avs_read,
   input  wire             avs_write,
   input  wire [31:0]      avs_writedata,
   input  wire [3:0]       avs_byteenable,
   output reg  [31:0]      avs_readdata,
   output wire             avs_waitrequest,
   output reg  [1:0]       avs_response,
   // Clocks and division state.
   input  wire             div_clk,
   input  wire             gpio_clk,
   input  wire [DIV_W-1:0] div_ratio,
   input  wire             sweep_dir_up,
   input  wire [47:0]      dwell_down,
   // Configuration toward the divider and modulator.
   output wire             mod_clk,
   output wire             mod_ext_clk_sel,
   output reg  [7:0]       slip_guard_step,
   output reg              mod_pulse_wide,
   output reg              cmp_pulse_wide,
   output reg              div_reset,
   output reg  [5:0]       div_pulse_cycles,
   output reg  [2:0]       buf_current_code,
   output reg  [2:0]       resync_bias_code,
   output reg  [2:0]       rf_bias_code,
   output reg  [47:0]      dwell_count,
   output reg  [47:0]      dwell_active,
   output reg              sym_sweep
);

////////////////////////////////////////////////////////////////////////////
// Register storage.

reg  [31:0] mod_ctrl_q;
reg  [14:0] div_cfg_q;
reg  [29:0] dwell_hi_q;
reg  [17:0] dwell_lo_q;
reg         ack_q;
reg  [31:0] wmask;
wire [5:0]  word_idx = avs_address[7:2];
wire        req = avs_read | avs_write;

// One wait cycle per access; the ack drops waitrequest after the first edge.
assign avs_waitrequest = req & ~ack_q;

always @* begin
   wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
            {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
end

always @(posedge core_clk) begin
   if (rst) begin
      ack_q        <= 1'b0;
      mod_ctrl_q   <= `FDS_MOD_CTRL_RST;
      div_cfg_q    <= `FDS_DIV_CFG_RST;
      dwell_hi_q   <= 30'h0000_0000;
      dwell_lo_q   <= 18'h0_0000;
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'b00;
   end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) begin
         avs_response <= 2'b00;
         avs_readdata <= 32'h0000_0000;
         if (word_idx == `FDS_IDX_MOD_CTRL) begin
            if (avs_write) begin
               mod_ctrl_q <= (mod_ctrl_q & ~(wmask & `FDS_MOD_CTRL_MASK)) |
                             (avs_writedata & wmask & `FDS_MOD_CTRL_MASK);
            end
            avs_readdata <= mod_ctrl_q;
         end else if (word_idx == `FDS_IDX_DIV_CFG) begin
            if (avs_write) begin
               div_cfg_q <= (div_cfg_q & ~wmask[14:0]) |
                            (avs_writedata[14:0] & wmask[14:0]);
            end
            avs_readdata <= {17'h0_0000, div_cfg_q};
         end else if (word_idx == `FDS_IDX_DWELL_HI) begin
            if (avs_write) begin
               dwell_hi_q <= (dwell_hi_q & ~wmask[29:0]) |
                             (avs_writedata[29:0] & wmask[29:0]);
            end
            avs_readdata <= {2'b00, dwell_hi_q};
         end else if (word_idx == `FDS_IDX_DWELL_LO) begin
            if (avs_write) begin
               dwell_lo_q <= (dwell_lo_q & ~wmask[17:0]) |
                             (avs_writedata[17:0] & wmask[17:0]);
            end
            avs_readdata <= {14'h0000, dwell_lo_q};
         end else begin
            // Unmapped words read zero and report a decode error.
            avs_response <= 2'b11;
         end
      end
   end
end

////////////////////////////////////////////////////////////////////////////
// Modulator clock selection.

// A plain mux, no glitch-free switcher: change the select only while the
// modulator is idle or held in reset.
assign mod_ext_clk_sel = mod_ctrl_q[`FDS_EXT_CLK_BIT];
assign mod_clk = mod_ext_clk_sel ? gpio_clk : div_clk;

////////////////////////////////////////////////////////////////////////////
// Registered configuration outputs.

wire [3:0] slip_base = mod_ctrl_q[`FDS_SLIP_STEP_MSB:`FDS_SLIP_STEP_LSB];
wire [2:0] pw_code   = div_cfg_q[`FDS_PW_MSB:`FDS_PW_LSB];
wire [DIV_W-1:0] wide_min = `FDS_WIDE_MIN_RATIO;
wire [47:0] dwell_w  = {dwell_hi_q, dwell_lo_q};

always @(posedge core_clk) begin
   if (rst) begin
      slip_guard_step  <= 8'h0f;
      mod_pulse_wide   <= 1'b0;
      cmp_pulse_wide   <= 1'b1;
      div_reset        <= 1'b0;
      div_pulse_cycles <= 6'h1d;
      buf_current_code <= 3'h3;
      resync_bias_code <= 3'h3;
      rf_bias_code     <= 3'h1;
      dwell_count      <= 48'h0000_0000_0000;
      dwell_active     <= 48'h0000_0000_0000;
      sym_sweep        <= 1'b1;
   end else begin
      if (mod_ctrl_q[`FDS_X16_BIT]) begin
         slip_guard_step <= {slip_base, 4'h0};
      end else begin
         slip_guard_step <= {4'h0, slip_base};
      end
      mod_pulse_wide <= div_cfg_q[`FDS_WIDE_MOD_BIT] &
                        (div_ratio > wide_min);
      cmp_pulse_wide <= div_cfg_q[`FDS_WIDE_CMP_BIT];
      div_reset      <= div_cfg_q[`FDS_DIVRST_BIT];
      div_pulse_cycles <= `FDS_PW_BASE +
                          {pw_code, 3'b000};
      buf_current_code <= div_cfg_q[`FDS_BUFCUR_MSB:`FDS_BUFCUR_LSB];
      resync_bias_code <= div_cfg_q[`FDS_RESYNC_MSB:`FDS_RESYNC_LSB];
      rf_bias_code     <= div_cfg_q[`FDS_RFBIAS_MSB:`FDS_RFBIAS_LSB];
      dwell_count      <= dwell_w;
      sym_sweep        <= mod_ctrl_q[`FDS_SYM_BIT];
      if (mod_ctrl_q[`FDS_SYM_BIT] | sweep_dir_up) begin
         dwell_active <= dwell_w;
      end else begin
         dwell_active <= dwell_down;
      end
   end
end

endmodule

// ===== tb/fds_vco_pfd_model.sv
// Far-side model: divided clock, GPIO clock and down-direction dwell.
`timescale 1ns/1ps
module fds_vco_pfd_model (
   // Core clock.
   input  wire         core_clk,
   // Far-side clocks and dwell.
   output logic        div_clk,
   output logic        gpio_clk,
   output logic [47:0] dwell_down
);
   // Clocks move only on core edges, so the clock select is sampled cleanly.
   initial begin
      div_clk = 1'b0;
      gpio_clk = 1'b0;
      dwell_down = {16'($urandom), $urandom};
   end
   always @(posedge core_clk) begin
      div_clk  <= ~div_clk;
      gpio_clk <= 1'($urandom);
   end
endmodule

// ===== tb/fds_divider_cfg_checker.sv
// Port checker for the divider configuration register bank.
`timescale 1ns/1ps
module fds_divider_cfg_checker #(parameter DIV_W = 20) (
   // Clock, reset and bus.
   input wire              core_clk, rst, avs_read, avs_write,
   input wire              avs_waitrequest,
   input wire [7:0]        avs_address,
   input wire [1:0]        avs_response,
   // Divider side.
   input wire              div_clk, gpio_clk, sweep_dir_up, sym_sweep,
   input wire              mod_clk, mod_ext_clk_sel, mod_pulse_wide,
   input wire [DIV_W-1:0]  div_ratio,
   input wire [7:0]        slip_guard_step,
   input wire [5:0]        div_pulse_cycles,
   input wire [47:0]       dwell_down, dwell_count, dwell_active
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   a_clk_select: assert property (mod_clk ==
      (mod_ext_clk_sel ? gpio_clk : div_clk)) else $error("bad mod clock");
   a_slip_step: assert property (slip_guard_step[7:4] == 4'h0 ||
      slip_guard_step[3:0] == 4'h0) else $error("bad slip step");
   a_wide_ratio: assert property (mod_pulse_wide |->
      $past(div_ratio) > 64) else $error("widening at low ratio");
   a_pulse_code: assert property (div_pulse_cycles[2:0] == 3'd5)
      else $error("bad pulse width");
   a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("wait too long");
   a_bad_addr: assert property ((avs_read || avs_write) && !avs_waitrequest
      |-> avs_response == ((avs_address[7:2] inside {[6'h0e:6'h11]}) ?
      2'b00 : 2'b11)) else $error("bad response");
   a_dwell_up: assert property (((sym_sweep || sweep_dir_up) &&
      $stable(dwell_count))[*3] |-> dwell_active == dwell_count)
      else $error("bad up dwell");
   a_dwell_down: assert property ((!sym_sweep && !sweep_dir_up)[*3]
      |-> dwell_active == dwell_down) else $error("bad down dwell");
   c_wide: cover property (mod_pulse_wide);
   c_down: cover property (!sym_sweep && !sweep_dir_up);
   c_err: cover property (avs_response == 2'b11);
endmodule
bind fds_divider_cfg fds_divider_cfg_checker #(.DIV_W(DIV_W)) i_chk (.*);

// ===== tb/fds_divider_cfg_tb.sv
// Self-checking bench for the divider configuration register bank.
`timescale 1ns/1ps
`include "fds_regs.vh"
module fds_divider_cfg_tb;
   logic        core_clk = 0, rst = 1, avs_read = 0, avs_write = 0;
   logic        sweep_dir_up = 0;
   logic [7:0]  avs_address = 0;
   logic [3:0]  avs_byteenable = 4'hf;
   logic [19:0] div_ratio = 0;
   logic [31:0] avs_writedata = 0, rd, v, h, l;
   logic [1:0]  rsp;
   wire         avs_waitrequest, div_clk, gpio_clk, mod_clk, mod_ext_clk_sel;
   wire         mod_pulse_wide, cmp_pulse_wide, div_reset, sym_sweep;
   wire [31:0]  avs_readdata;
   wire [1:0]   avs_response;
   wire [7:0]   slip_guard_step;
   wire [5:0]   div_pulse_cycles;
   wire [2:0]   buf_current_code, resync_bias_code, rf_bias_code;
   wire [47:0]  dwell_down, dwell_count, dwell_active;
   int          bad_count = 0, cmp_count = 0;
   always #10 core_clk = ~core_clk;
   fds_divider_cfg i_fds_divider_cfg (.*);
   fds_vco_pfd_model i_fds_vco_pfd_model (.core_clk, .div_clk, .gpio_clk,
      .dwell_down);
   function automatic logic [5:0] pw(input logic [2:0] c);
      return 6'd5 + {c, 3'b000};
   endfunction
   task automatic chk(input string nm, input logic [47:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // The request stands until waitrequest is sampled low at a rising edge.
   task automatic bus(input logic wr, input logic [5:0] a,
                      input logic [31:0] d);
      @(posedge core_clk);
      avs_address <= {a, 2'b00};
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge core_clk);
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      rsp = avs_response;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic close_out;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge core_clk);
      bad_count++;
      close_out;
   end
   initial begin
      void'($urandom(11073));
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      bus(0, `FDS_IDX_MOD_CTRL, 0);
      chk("mod_ctrl", rd, `FDS_MOD_CTRL_RST);
      bus(0, `FDS_IDX_DIV_CFG, 0);
      chk("div_cfg", rd, `FDS_DIV_CFG_RST);
      chk("dwell_rst", dwell_count, 0);
      for (int k = 0; k < 8; k++) begin
         v = $urandom;
         v[14:12] = k[2:0];
         bus(1, `FDS_IDX_DIV_CFG, v);
         bus(0, `FDS_IDX_DIV_CFG, 0);
         chk("div_cfg", rd, {17'h0_0000, v[14:0]});
         chk("pulse", div_pulse_cycles, pw(v[14:12]));
         chk("cmp", cmp_pulse_wide, v[1]);
         chk("div_reset", div_reset, v[5]);
         chk("buf", buf_current_code, v[4:2]);
         chk("resync", resync_bias_code, v[8:6]);
         chk("rfbias", rf_bias_code, v[11:9]);
      end
      bus(1, `FDS_IDX_DIV_CFG, 32'h0000_0001);
      for (int k = 0; k < 6; k++) begin
         @(posedge core_clk);
         if (k < 4) div_ratio <= 20'(63 + k);
         else sweep_dir_up <= k[0];
         repeat (3) @(negedge core_clk);
         if (k < 4) chk("mod_wide", mod_pulse_wide, k > 1);
         if (k == 1) begin
            v = $urandom | 32'h2040_0000;
            bus(1, `FDS_IDX_MOD_CTRL, v);
            bus(0, `FDS_IDX_MOD_CTRL, 0);
            chk("mod_ctrl", rd, v & `FDS_MOD_CTRL_MASK);
            chk("slip", slip_guard_step, {v[18:15], 4'h0});
            chk("ext_sel", mod_ext_clk_sel, v[27]);
            chk("sym", sym_sweep, 1'b1);
            bus(1, `FDS_IDX_MOD_CTRL, 32'h0000_8000);
            @(posedge core_clk);
            chk("slip1", slip_guard_step, 8'h01);
         end
         if (k == 3) begin
            h = $urandom;
            l = $urandom;
            bus(1, `FDS_IDX_DWELL_HI, h);
            bus(1, `FDS_IDX_DWELL_LO, l);
            bus(0, `FDS_IDX_DWELL_LO, 0);
            chk("dwell_lo", rd, l[17:0]);
            chk("dwell", dwell_count, {h[29:0], l[17:0]});
         end
         if (k > 3) chk("active", dwell_active,
            k[0] ? {h[29:0], l[17:0]} : dwell_down);
      end
      bus(1, 6'h20, 32'hffff_ffff);
      bus(0, 6'h20, 0);
      chk("unmapped", {rsp, rd}, {2'b11, 32'h0000_0000});
      close_out;
   end
endmodule
